/* hdl/acpc_dev_end.sv */
// converter end: clock divider and alignment, power sequencing, background calibration control
`timescale 1ns/100ps
`default_nettype none
`include "acpc_params.svh"
module acpc_dev_end #(
    parameter logic [35:0] CAL_PERIOD = `ACPC_CAL_PERIOD,
    parameter int NUM_PATHS = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    acpc_if.dev link,
    input wire logic [NUM_PATHS-1:0] overRange,
    input wire logic [NUM_PATHS-1:0] farOverRange,
    input wire logic clkBelowMin,
    output logic sampleTick,
    output logic dcsActive,
    output logic refPowered,
    output logic [NUM_PATHS-1:0] calUpdate,
    output logic [NUM_PATHS-1:0] calFast
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] pwrMode, divRatio, phaseAdj, alignCtl, stbyRecov, calCtl, rdData;
    logic [7:0] next_pwrMode, next_divRatio, next_phaseAdj, next_alignCtl;
    logic [7:0] next_stbyRecov, next_calCtl, next_rdData;
    logic rdValid, next_rdValid, alignArmed, next_alignArmed, calKick;
    logic alignHit;
    acpc_pkg::acpc_pmode_t curMode, next_curMode, effMode;
    logic [1:0] calFastAny;

    always_comb begin
        next_pwrMode = pwrMode;
        next_divRatio = divRatio;
        next_phaseAdj = phaseAdj;
        next_alignCtl = alignCtl;
        next_stbyRecov = stbyRecov;
        next_calCtl = calCtl;
        next_rdData = rdData;
        next_rdValid = 1'b0;
        next_alignArmed = alignArmed & ~alignHit;
        calKick = 1'b0;
        if (link.regStrobe && link.regWrite) begin
            unique case (link.regAddr)
                `ACPC_REG_PWR: next_pwrMode = link.regWrData;
                `ACPC_REG_DIV: next_divRatio = link.regWrData;
                `ACPC_REG_PHASE: next_phaseAdj = link.regWrData;
                `ACPC_REG_ALIGN: begin
                    next_alignCtl = link.regWrData;
                    next_alignArmed = 1'b1;
                end
                `ACPC_REG_STBY: next_stbyRecov = link.regWrData;
                `ACPC_REG_CAL: begin
                    // every bit is stored so read-modify-write keeps reserved bits
                    next_calCtl = link.regWrData;
                    calKick = (calCtl == `ACPC_CAL_KICK_FIRST) &&
                              (link.regWrData == `ACPC_CAL_KICK_SECOND);
                end
                default: ;
            endcase
        end else if (link.regStrobe) begin
            next_rdValid = 1'b1;
            unique case (link.regAddr)
                `ACPC_REG_PWR: next_rdData = pwrMode;
                `ACPC_REG_DIV: next_rdData = divRatio;
                `ACPC_REG_PHASE: next_rdData = phaseAdj;
                `ACPC_REG_ALIGN: next_rdData = alignCtl;
                `ACPC_REG_STBY: next_rdData = stbyRecov;
                `ACPC_REG_CAL: next_rdData = calCtl;
                `ACPC_REG_STATUS: next_rdData = {dcsActive, alignArmed, calFastAny,
                                                 2'b00, curMode};
                default: next_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pwrMode <= `ACPC_RST_PWR;
            divRatio <= `ACPC_RST_DIV;
            phaseAdj <= `ACPC_RST_PHASE;
            alignCtl <= `ACPC_RST_ALIGN;
            stbyRecov <= `ACPC_RST_STBY;
            calCtl <= `ACPC_RST_CAL;
            rdData <= 8'h00;
            rdValid <= 1'b0;
            alignArmed <= 1'b0;
        end else begin
            pwrMode <= next_pwrMode;
            divRatio <= next_divRatio;
            phaseAdj <= next_phaseAdj;
            alignCtl <= next_alignCtl;
            stbyRecov <= next_stbyRecov;
            calCtl <= next_calCtl;
            rdData <= next_rdData;
            rdValid <= next_rdValid;
            alignArmed <= next_alignArmed;
        end
    end

    assign link.regRdData = rdData;
    assign link.regRdValid = rdValid;
    assign calFastAny = {1'b0, |calFast};

    // ------------------------------------------------------------
    // pin synchronisers and align edge
    // ------------------------------------------------------------
    logic [1:0] pdSync, alSync;
    logic alPrev, alRise;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pdSync <= 2'b00;
            alSync <= 2'b00;
            alPrev <= 1'b0;
        end else begin
            pdSync <= {pdSync[0], link.powerDownPin};
            alSync <= {alSync[0], link.alignPulse};
            alPrev <= alSync[1];
        end
    end

    assign alRise = alSync[1] & ~alPrev;

    // ------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------
    logic [2:0] divCnt, next_divCnt, divMax;
    logic next_sampleTick;

    assign divMax = 3'((4'd1 << divRatio[1:0]) - 4'd1);
    assign alignHit = alRise && (alignCtl[`ACPC_ALIGN_EVERY_BIT] ||
                      (alignCtl[`ACPC_ALIGN_FIRST_BIT] && alignArmed));

    always_comb begin
        if (alignHit) begin
            // restart then slip by whole input cycles; no effect when dividing by 1
            next_divCnt = phaseAdj[2:0] & divMax;
        end else if (divCnt >= divMax) begin
            next_divCnt = 3'd0;
        end else begin
            next_divCnt = divCnt + 3'd1;
        end
        next_sampleTick = (next_divCnt == 3'd0) && (curMode != acpc_pkg::ACPC_PM_DOWN);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            divCnt <= 3'd0;
            sampleTick <= 1'b0;
        end else begin
            divCnt <= next_divCnt;
            sampleTick <= next_sampleTick;
        end
    end

    // ------------------------------------------------------------
    // power modes and stabilizer lock
    // ------------------------------------------------------------
    logic leaving, wakeFast;
    logic [1:0] lastRatio;
    logic [9:0] relockCnt, next_relockCnt;

    always_comb begin
        if (pdSync[1]) begin
            effMode = (pwrMode[1:0] == 2'h2) ? acpc_pkg::ACPC_PM_STANDBY
                                            : acpc_pkg::ACPC_PM_DOWN;
        end else if (pwrMode[1:0] == 2'h0) begin
            effMode = acpc_pkg::ACPC_PM_NORMAL;
        end else begin
            effMode = (pwrMode[1:0] == 2'h2) ? acpc_pkg::ACPC_PM_STANDBY
                                            : acpc_pkg::ACPC_PM_DOWN;
        end
        next_curMode = effMode;
        leaving = (curMode != acpc_pkg::ACPC_PM_NORMAL) &&
                  (effMode == acpc_pkg::ACPC_PM_NORMAL);
        wakeFast = leaving && !((curMode == acpc_pkg::ACPC_PM_STANDBY) &&
                   (stbyRecov == `ACPC_STBY_KEEP));
        // a ratio change or a clock restart means the loop must relock
        if ((divRatio[1:0] != lastRatio) || (leaving && curMode == acpc_pkg::ACPC_PM_DOWN)) begin
            next_relockCnt = 10'(`ACPC_DCS_RELOCK_CYC);
        end else if (relockCnt != 10'd0) begin
            next_relockCnt = relockCnt - 10'd1;
        end else begin
            next_relockCnt = relockCnt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            curMode <= acpc_pkg::ACPC_PM_NORMAL;
            lastRatio <= 2'b00;
            relockCnt <= 10'd0;
        end else begin
            curMode <= next_curMode;
            lastRatio <= divRatio[1:0];
            relockCnt <= next_relockCnt;
        end
    end

    assign link.outDriveEn = (curMode != acpc_pkg::ACPC_PM_DOWN);
    assign refPowered = (curMode != acpc_pkg::ACPC_PM_DOWN);
    // high means the falling edge is regenerated for half duty; low means input edges pass
    assign dcsActive = divRatio[`ACPC_DIV_DCS_BIT] && (relockCnt == 10'd0) &&
                       !clkBelowMin && (curMode != acpc_pkg::ACPC_PM_DOWN);

    // ------------------------------------------------------------
    // background calibration, one engine per path
    // ------------------------------------------------------------
    logic calRun;
    assign calRun = sampleTick && !calCtl[`ACPC_CAL_PAUSE_BIT] &&
                    (curMode == acpc_pkg::ACPC_PM_NORMAL);

    for (genvar p = 0; p < NUM_PATHS; p++) begin : g_path
        logic [35:0] cnt, next_cnt, period;
        logic [9:0] ovr, next_ovr;
        logic blocked, next_blocked, fast, next_fast, next_update;

        always_comb begin
            period = fast ? (CAL_PERIOD / 36'(`ACPC_CAL_FAST_DIV)) : CAL_PERIOD;
            next_cnt = cnt;
            next_ovr = ovr;
            next_blocked = blocked;
            next_fast = fast;
            next_update = 1'b0;
            if (calKick || wakeFast) begin
                next_cnt = 36'd0;
                next_ovr = 10'd0;
                next_blocked = 1'b0;
                next_fast = 1'b1;
            end else if (calRun) begin
                if (farOverRange[p]) begin
                    next_blocked = 1'b1;
                end
                if (overRange[p] && (ovr == 10'(`ACPC_OVR_LIMIT - 1))) begin
                    next_cnt = 36'd0;
                    next_ovr = 10'd0;
                    next_blocked = 1'b0;
                end else if (cnt == period - 36'd1) begin
                    next_update = !(blocked || farOverRange[p]);
                    next_fast = 1'b0;
                    next_cnt = 36'd0;
                    next_ovr = 10'd0;
                    next_blocked = 1'b0;
                end else begin
                    next_cnt = cnt + 36'd1;
                    next_ovr = ovr + 10'(overRange[p]);
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                cnt <= 36'd0;
                ovr <= 10'd0;
                blocked <= 1'b0;
                fast <= 1'b1;
                calUpdate[p] <= 1'b0;
            end else begin
                cnt <= next_cnt;
                ovr <= next_ovr;
                blocked <= next_blocked;
                fast <= next_fast;
                calUpdate[p] <= next_update;
            end
        end

        assign calFast[p] = fast;
    end
endmodule // acpc_dev_end
`default_nettype wire

/* common/acpc_params.svh */
// register offsets, field positions, reset values and timing counts of the clock/power/calibration control
`ifndef ACPC_PARAMS_SVH
`define ACPC_PARAMS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ACPC_ADDR_W 12
`define ACPC_REG_PWR 12'h008
`define ACPC_REG_DIV 12'h00B
`define ACPC_REG_PHASE 12'h016
`define ACPC_REG_ALIGN 12'h100
`define ACPC_REG_STBY 12'h4FA
`define ACPC_REG_CAL 12'h4FB
`define ACPC_REG_STATUS 12'h4FC

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ACPC_DIV_DCS_BIT 7
`define ACPC_ALIGN_EVERY_BIT 1
`define ACPC_ALIGN_FIRST_BIT 2
`define ACPC_CAL_PAUSE_BIT 0

// ------------------------------------------------------------
// reset values and command values
// ------------------------------------------------------------
`define ACPC_RST_PWR 8'h00
`define ACPC_RST_DIV 8'h80
`define ACPC_RST_PHASE 8'h00
`define ACPC_RST_ALIGN 8'h00
`define ACPC_RST_STBY 8'h01
`define ACPC_RST_CAL 8'h08
`define ACPC_STBY_KEEP 8'h00
`define ACPC_CAL_KICK_FIRST 8'h0C
`define ACPC_CAL_KICK_SECOND 8'h08

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ACPC_CLK_PERIOD_NS 10
`define ACPC_DCS_RELOCK_MIN_NS 1500
`define ACPC_DCS_WAIT_MAX_NS 5000
`define ACPC_DCS_RELOCK_CYC \
    ((`ACPC_DCS_RELOCK_MIN_NS + `ACPC_CLK_PERIOD_NS - 1) / `ACPC_CLK_PERIOD_NS)
`define ACPC_HOST_WAIT_CYC \
    ((`ACPC_DCS_WAIT_MAX_NS + `ACPC_CLK_PERIOD_NS - 1) / `ACPC_CLK_PERIOD_NS)
`define ACPC_CAL_PERIOD 36'h6_0000_0000
`define ACPC_CAL_FAST_DIV 64
`define ACPC_OVR_LIMIT 1000

`endif

/* common/acpc_pkg.sv */
// types shared by both ends of the clock/power/calibration control
package acpc_pkg;

    // ------------------------------------------------------------
    // power modes, as coded in the power mode bits
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACPC_PM_NORMAL = 2'h0,
        ACPC_PM_DOWN = 2'h1,
        ACPC_PM_STANDBY = 2'h2,
        ACPC_PM_RSVD = 2'h3
    } acpc_pmode_t;

    // ------------------------------------------------------------
    // host commands and host states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACPC_CMD_WRITE = 3'h0,
        ACPC_CMD_READ = 3'h1,
        ACPC_CMD_PAUSE = 3'h2,
        ACPC_CMD_RESUME = 3'h3,
        ACPC_CMD_FASTCAL_REG = 3'h4,
        ACPC_CMD_FASTCAL_STBY = 3'h5,
        ACPC_CMD_FASTCAL_DOWN = 3'h6
    } acpc_cmd_t;

    typedef enum logic [1:0] {
        ACPC_H_IDLE = 2'b00,
        ACPC_H_RDWAIT = 2'b01,
        ACPC_H_SECOND = 2'b11
    } acpc_hstate_t;

endpackage

/* common/acpc_if.sv */
// link between the host controller and the converter control logic
`timescale 1ns/100ps
`default_nettype none
interface acpc_if;
    logic regStrobe;
    logic regWrite;
    logic [11:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic regRdValid;
    logic powerDownPin;
    logic alignPulse;
    logic outDriveEn;

    modport dev (
        input regStrobe, regWrite, regAddr, regWrData, powerDownPin, alignPulse,
        output regRdData, regRdValid, outDriveEn
    );
    modport host (
        output regStrobe, regWrite, regAddr, regWrData, powerDownPin, alignPulse,
        input regRdData, regRdValid, outDriveEn
    );
endinterface
`default_nettype wire

/* hdl/acpc_host_end.sv */
// host end: register access, pause by read-modify-write, fast calibration sequences, pins
`timescale 1ns/100ps
`default_nettype none
`include "acpc_params.svh"
module acpc_host_end (
    input wire logic clk_sys,
    input wire logic sys_rst,
    acpc_if.host link,
    input wire logic cmdValid,
    input wire acpc_pkg::acpc_cmd_t cmdKind,
    input wire logic [11:0] cmdAddr,
    input wire logic [7:0] cmdData,
    input wire logic dcsBypassAllowed,
    input wire logic powerDownReq,
    input wire logic alignReq,
    output logic cmdReady,
    output logic rspValid,
    output logic [7:0] rspData,
    output logic timingStable
);
    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    acpc_pkg::acpc_hstate_t state, next_state;
    logic stb, wr, rmw, pauseVal, next_stb, next_wr, next_rmw, next_pauseVal;
    logic [11:0] addr, next_addr;
    logic [7:0] data, next_data, second, next_second, next_rspData;
    logic next_rspValid;
    logic [9:0] waitCnt, next_waitCnt;

    always_comb begin
        next_state = state;
        next_stb = 1'b0;
        next_wr = 1'b0;
        next_addr = addr;
        next_data = data;
        next_rmw = rmw;
        next_pauseVal = pauseVal;
        next_second = second;
        next_rspValid = 1'b0;
        next_rspData = rspData;
        unique case (state)
            acpc_pkg::ACPC_H_IDLE: begin
                if (cmdValid) begin
                    next_stb = 1'b1;
                    next_addr = cmdAddr;
                    next_data = cmdData;
                    unique case (cmdKind)
                        acpc_pkg::ACPC_CMD_WRITE: begin
                            next_wr = 1'b1;
                            if (cmdAddr == `ACPC_REG_DIV && !dcsBypassAllowed) begin
                                next_data[`ACPC_DIV_DCS_BIT] = 1'b1;
                            end
                        end
                        acpc_pkg::ACPC_CMD_READ: begin
                            next_rmw = 1'b0;
                            next_state = acpc_pkg::ACPC_H_RDWAIT;
                        end
                        acpc_pkg::ACPC_CMD_PAUSE, acpc_pkg::ACPC_CMD_RESUME: begin
                            next_addr = `ACPC_REG_CAL;
                            next_rmw = 1'b1;
                            next_pauseVal = (cmdKind == acpc_pkg::ACPC_CMD_PAUSE);
                            next_state = acpc_pkg::ACPC_H_RDWAIT;
                        end
                        acpc_pkg::ACPC_CMD_FASTCAL_REG: begin
                            next_wr = 1'b1;
                            next_addr = `ACPC_REG_CAL;
                            next_data = `ACPC_CAL_KICK_FIRST;
                            next_second = `ACPC_CAL_KICK_SECOND;
                            next_state = acpc_pkg::ACPC_H_SECOND;
                        end
                        default: begin
                            next_wr = 1'b1;
                            next_addr = `ACPC_REG_PWR;
                            next_data = (cmdKind == acpc_pkg::ACPC_CMD_FASTCAL_STBY) ?
                                        8'h02 : 8'h01;
                            next_second = 8'h00;
                            next_state = acpc_pkg::ACPC_H_SECOND;
                        end
                    endcase
                end
            end
            acpc_pkg::ACPC_H_RDWAIT: begin
                if (link.regRdValid) begin
                    next_state = acpc_pkg::ACPC_H_IDLE;
                    if (rmw) begin
                        next_stb = 1'b1;
                        next_wr = 1'b1;
                        next_data = link.regRdData;
                        next_data[`ACPC_CAL_PAUSE_BIT] = pauseVal;
                    end else begin
                        next_rspValid = 1'b1;
                        next_rspData = link.regRdData;
                    end
                end
            end
            acpc_pkg::ACPC_H_SECOND: begin
                next_stb = 1'b1;
                next_wr = 1'b1;
                next_data = second;
                next_state = acpc_pkg::ACPC_H_IDLE;
            end
            default: next_state = acpc_pkg::ACPC_H_IDLE;
        endcase
        // after a divide change the stabilizer may need the longest relock time
        if (stb && wr && addr == `ACPC_REG_DIV) begin
            next_waitCnt = 10'(`ACPC_HOST_WAIT_CYC);
        end else if (waitCnt != 10'd0) begin
            next_waitCnt = waitCnt - 10'd1;
        end else begin
            next_waitCnt = waitCnt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= acpc_pkg::ACPC_H_IDLE;
            stb <= 1'b0;
            wr <= 1'b0;
            addr <= 12'h000;
            data <= 8'h00;
            rmw <= 1'b0;
            pauseVal <= 1'b0;
            second <= 8'h00;
            rspValid <= 1'b0;
            rspData <= 8'h00;
            waitCnt <= 10'd0;
            link.powerDownPin <= 1'b0;
            link.alignPulse <= 1'b0;
        end else begin
            state <= next_state;
            stb <= next_stb;
            wr <= next_wr;
            addr <= next_addr;
            data <= next_data;
            rmw <= next_rmw;
            pauseVal <= next_pauseVal;
            second <= next_second;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
            waitCnt <= next_waitCnt;
            link.powerDownPin <= powerDownReq;
            link.alignPulse <= alignReq;
        end
    end

    assign link.regStrobe = stb;
    assign link.regWrite = wr;
    assign link.regAddr = addr;
    assign link.regWrData = data;
    // one strobe in flight at a time keeps the second write of a pair in order
    assign cmdReady = (state == acpc_pkg::ACPC_H_IDLE) && !stb;
    assign timingStable = (waitCnt == 10'd0);
endmodule // acpc_host_end
`default_nettype wire

/* sim/acpc_link_asserts.sv */
// link assertions for the converter control interface
`timescale 1ns/100ps
`default_nettype none
module acpc_link_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic regStrobe,
    input wire logic regWrite,
    input wire logic [11:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic powerDownPin,
    input wire logic outDriveEn
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ----
    // mode bits as last written, so pin effects can be judged
    // ----
    logic rd, wr, calWr, pwrWr;
    logic [1:0] pm, next_pm;
    assign rd = regStrobe && !regWrite;
    assign wr = regStrobe && regWrite;
    assign calWr = wr && regAddr == 12'h4FB;
    assign pwrWr = wr && regAddr == 12'h008;
    always_comb begin
        next_pm = pm;
        if (pwrWr) next_pm = regWrData[1:0];
        if (sys_rst) next_pm = 2'h0;
    end
    always_ff @(posedge clk_sys) pm <= next_pm;
    sequence s_rd_then_cal_wr;
        regRdValid ##1 calWr;
    endsequence
    a_rd_answer: assert property (rd |=> regRdValid ##1 !regRdValid)
        else $error("read answer not a one-cycle pulse");
    a_rmw_keep: assert property (s_rd_then_cal_wr |-> regWrData[7:1] == regRdData[7:1])
        else $error("reserved calibration bits not kept");
    a_kick_pair: assert property (calWr && regWrData == 8'h0C |=> calWr && regWrData == 8'h08)
        else $error("kick pair broken");
    a_stby_pair: assert property (pwrWr && regWrData == 8'h02 |=> pwrWr && regWrData == 8'h00)
        else $error("standby pair broken");
    a_host_dcs: assert property (wr && regAddr == 12'h00B |-> regWrData[7])
        else $error("stabilizer left disabled");
    a_pin_down: assert property ((powerDownPin && pm != 2'h2) [*5] |-> !outDriveEn)
        else $error("drivers on during pin power-down");
    a_reg_down: assert property ((pm == 2'h1) [*4] |-> !outDriveEn)
        else $error("drivers on during register power-down");
    a_pin_wake: assert property ((!powerDownPin && pm == 2'h0) [*5] |-> outDriveEn)
        else $error("drivers off in normal mode");
endmodule // acpc_link_asserts
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench joining the host end and the converter end
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam acpc_pkg::acpc_cmd_t cmdWr = acpc_pkg::ACPC_CMD_WRITE;
    logic clk_sys = 1'b0, sys_rst = 1'b1, cmdValid = 1'b0, powerDownReq = 1'b0;
    logic alignReq = 1'b0, clkBelowMin = 1'b0;
    acpc_pkg::acpc_cmd_t cmdKind = cmdWr;
    logic [11:0] cmdAddr = 12'h000;
    logic [7:0] cmdData = 8'h00, rspData, d;
    logic [1:0] overRange = 2'b00, farOverRange = 2'b00, calUpdate, calFast;
    logic cmdReady, rspValid, timingStable, sampleTick, dcsActive, refPowered;
    logic [7:0] q[$];
    logic [19:0] rstTab [7] = '{20'h0_0800, 20'h0_0B80, 20'h0_1600, 20'h1_0000, 20'h4_FA01,
        20'h4_FB08, 20'h1_2300};
    int bad_count = 0, tests_run = 0, seed = 32'h12d0, n, t0;
    acpc_if link();
    acpc_host_end u_acpc_host_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link),
        .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .dcsBypassAllowed(1'b0), .powerDownReq(powerDownReq), .alignReq(alignReq),
        .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .timingStable(timingStable));
    acpc_dev_end #(.CAL_PERIOD(36'h1000)) u_acpc_dev_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .link(link), .overRange(overRange), .farOverRange(farOverRange), .clkBelowMin(clkBelowMin),
        .sampleTick(sampleTick), .dcsActive(dcsActive), .refPowered(refPowered),
        .calUpdate(calUpdate), .calFast(calFast));
    acpc_link_asserts u_asserts (.clk_sys(clk_sys), .sys_rst(sys_rst), .regStrobe(link.regStrobe),
        .regWrite(link.regWrite), .regAddr(link.regAddr), .regWrData(link.regWrData),
        .regRdData(link.regRdData), .regRdValid(link.regRdValid),
        .powerDownPin(link.powerDownPin), .outDriveEn(link.outDriveEn));
    // ----
    // shared tasks
    // ----
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cmd(input acpc_pkg::acpc_cmd_t k, input logic [11:0] a, input logic [7:0] v);
        cmdValid <= 1'b1;
        cmdKind <= k;
        cmdAddr <= a;
        cmdData <= v;
        do @(posedge clk_sys); while (cmdReady !== 1'b1);
        cmdValid <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        q.push_back(e);
        cmd(acpc_pkg::ACPC_CMD_READ, a, 8'h00);
    endtask
    task automatic wfast(input logic [1:0] e);
        for (n = 0; n < 600 && calFast !== e; n++) @(posedge clk_sys);
        chk({6'h00, calFast}, {6'h00, e}, "calFast");
    endtask
    // counts ticks and two-path updates; a lone path update would hint at a split cycle
    task automatic tally(input int cyc, output int ticks, output int upd);
        ticks = 0;
        upd = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            if (sampleTick === 1'b1) ticks++;
            if (calUpdate === 2'b11) upd++;
        end
    endtask
    always @(posedge clk_sys) begin
        if (rspValid === 1'b1 && q.size() > 0) chk(rspData, q.pop_front(), "rspData");
    end
    initial forever #5 clk_sys = ~clk_sys;
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk({6'h00, calFast}, 8'h03, "calFast");
        foreach (rstTab[i]) rd(rstTab[i][19:8], rstTab[i][7:0]);
        d = 8'($random(seed));
        cmd(cmdWr, 12'h016, d);
        rd(12'h016, d);
        cmd(acpc_pkg::ACPC_CMD_PAUSE, 12'h4FB, 8'h00);
        rd(12'h4FB, 8'h09);
        cmd(acpc_pkg::ACPC_CMD_RESUME, 12'h4FB, 8'h00);
        rd(12'h4FB, 8'h08);
        for (int k = 4; k < 7; k++) begin
            wfast(2'b00);
            cmd(acpc_pkg::acpc_cmd_t'(k), 12'h000, 8'h00);
            wfast(2'b11);
        end
        wfast(2'b00);
        cmd(cmdWr, 12'h4FA, 8'h00);
        cmd(acpc_pkg::ACPC_CMD_FASTCAL_STBY, 12'h000, 8'h00);
        repeat (20) @(posedge clk_sys);
        chk({6'h00, calFast}, 8'h00, "calFast");
        cmd(cmdWr, 12'h4FA, 8'h01);
        powerDownReq <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk({6'h00, link.outDriveEn, refPowered}, 8'h00, "power-down");
        powerDownReq <= 1'b0;
        wfast(2'b11);
        cmd(cmdWr, 12'h008, 8'h01);
        repeat (4) @(posedge clk_sys);
        chk({7'h00, link.outDriveEn}, 8'h00, "outDriveEn");
        cmd(cmdWr, 12'h008, 8'h00);
        farOverRange <= 2'b11;
        tally(4200, t0, n);
        chk(8'(n), 8'h00, "blocked updates");
        farOverRange <= 2'b00;
        tally(4200, t0, n);
        tally(4096, t0, n);
        chk(8'(n), 8'h01, "updates per period");
        overRange <= 2'b11;
        tally(4200, t0, n);
        chk(8'(n), 8'h00, "restarted cycles");
        overRange <= 2'b00;
        for (int k = 3; k >= 0; k--) begin
            cmd(cmdWr, 12'h00B, 8'(k));
            @(posedge clk_sys);
            chk({6'h00, dcsActive, timingStable}, 8'h00, "relock");
            repeat (160) @(posedge clk_sys);
            chk({6'h00, dcsActive, timingStable}, 8'h02, "relock");
            repeat (350) @(posedge clk_sys);
            tally(64, n, t0);
            chk(8'(n), 8'(64 >> k), "ticks");
        end
        cmd(cmdWr, 12'h00B, 8'h03);
        cmd(cmdWr, 12'h100, 8'h02);
        for (int k = 0; k < 2; k++) begin
            repeat (3 + ($random(seed) & 7)) @(posedge clk_sys);
            alignReq <= 1'b1;
            repeat (6) @(posedge clk_sys);
            for (n = 0; n < 20 && sampleTick !== 1'b1; n++) @(posedge clk_sys);
            alignReq <= 1'b0;
            if (k == 0) t0 = n;
        end
        chk(8'(n), 8'(t0), "align phase");
        clkBelowMin <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk({7'h00, dcsActive}, 8'h00, "dcsActive");
        clkBelowMin <= 1'b0;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
